/* File: src/dacc_ctrl.sv */
// Operation
// - Shorted test jumper puts the block in calibration test mode.
// - Open test jumper runs normal mode, driving converted values out.
// - On host stop: hold last output if retain jumper shorted, else clear.
// - Retain jumper open, the factory state, means clear on host stop.
// - Output follows retain choice, output enable flag and channel enable.
// - Power-up calibration gives 10 V or 20 mA gain, 0 V or 4 mA offset.
// - Offset and gain may be changed only in test mode.
// - Entering test mode halts conversion on all channels at once.
// - Leaving test mode restarts all channels with the new calibration.
// - Adjusted value is stored only when selector moves to store position.
// - Test exit with selector at offset or gain keeps old values.
// - Run LED flickers every 0.1 s while adjusted value is out of range.
// - Store is refused while the out-of-range flicker is active.
// - Tap under 1.5 s steps once; longer hold steps every 0.02 s.
// - Run LED flashes slowly while selector is at offset or gain.
// - Channel selector picks 1 to 8, test mode only; 0 and 9 ignored.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dacc_ctrl import dacc_pkg::*; #(
  parameter logic CURRENT_VARIANT = 1'b0,
  parameter int LONG_CYC = LONG_PRESS_CYC,
  parameter int REP_CYC = REPEAT_CYC,
  parameter int FAST_CYC = FAST_BLINK_CYC,
  parameter int SLOW_CYC = SLOW_BLINK_CYC,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire dacc_bus_type bus,
  output logic [31:0] rd_data,
  // Front panel and host state
  input wire dacc_panel_type panel,
  input wire logic cpu_run,
  // Converter drive and indicators
  output dacc_chan_type [NCH-1:0] chan,
  output logic run_led,
  output logic irq
);
  dacc_panel_type pnl;
  dacc_debounce #(.W(10), .DEB_CYC(DEB_CYC)) u_deb (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(panel),
    .clean(pnl)
  );

  // Mode
  dacc_mode_type mode_ff, nxt_mode;
  always_comb begin
    case (mode_ff)
      MODE_NORMAL: nxt_mode = pnl.test_short ? MODE_TEST : MODE_NORMAL;
      MODE_TEST: nxt_mode = pnl.test_short ? MODE_TEST : MODE_NORMAL;
      default: nxt_mode = MODE_NORMAL;
    endcase
  end
  wire in_test = mode_ff == MODE_TEST;
  wire test_enter = !in_test && nxt_mode == MODE_TEST;
  wire test_exit = in_test && nxt_mode == MODE_NORMAL;

  // Calibration selection
  logic [1:0] sel_q_ff;
  wire sel_adj = pnl.cal_sel == SEL_OFFSET || pnl.cal_sel == SEL_GAIN;
  wire q_adj = sel_q_ff == SEL_OFFSET || sel_q_ff == SEL_GAIN;
  wire adj_active = in_test && sel_adj;
  wire ch_valid = pnl.ch_sel >= 4'h1 && pnl.ch_sel <= 4'h8;
  wire [2:0] ch_idx = 3'(pnl.ch_sel - 4'h1);
  wire is_gain = pnl.cal_sel == SEL_GAIN;
  // Switching into a position reloads the edit value; a channel change
  // does not, so a pending value follows the knob to the new channel
  wire load_work = adj_active && (!q_adj || sel_q_ff != pnl.cal_sel);
  wire store_try = in_test && q_adj && pnl.cal_sel == SEL_STORE && ch_valid;

  logic signed [NCH-1:0][15:0] st_offs, st_gain;
  logic signed [15:0] work_ff;
  logic range_err_ff;
  wire store_ok = store_try && !range_err_ff;
  dacc_cal_store #(.CURRENT_VARIANT(CURRENT_VARIANT)) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(store_ok),
    .wr_gain(sel_q_ff == SEL_GAIN),
    .wr_ch(ch_idx),
    .wr_val(work_ff),
    .offs(st_offs),
    .gain(st_gain)
  );

  // Up/down stepping with auto-repeat
  logic press_q_ff;
  logic [27:0] hold_cnt_ff;
  logic [27:0] rep_cnt_ff;
  wire press = pnl.up ^ pnl.down;
  wire long_held = hold_cnt_ff == 28'(LONG_CYC - 1);
  wire rep_due = long_held && rep_cnt_ff == 28'(REP_CYC - 1);
  wire step = adj_active && ch_valid && press && (!press_q_ff || rep_due);
  wire signed [15:0] lim_min = CURRENT_VARIANT ? I_MIN : V_MIN;
  wire signed [15:0] lim_max = CURRENT_VARIANT ? I_MAX : V_MAX;
  wire signed [15:0] cur_offs = st_offs[ch_idx];
  wire signed [15:0] cur_gain = st_gain[ch_idx];
  wire signed [15:0] nxt_work = load_work ? (is_gain ? cur_gain : cur_offs)
                              : step ? (pnl.up ? work_ff + 16'sh0001
                                               : work_ff - 16'sh0001)
                              : work_ff;
  wire nxt_err = adj_active && (nxt_work < lim_min || nxt_work > lim_max
                 || (is_gain ? nxt_work <= cur_offs : nxt_work >= cur_gain));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      press_q_ff <= 1'b0;
      hold_cnt_ff <= 28'h0000000;
      rep_cnt_ff <= 28'h0000000;
    end else begin
      press_q_ff <= press;
      hold_cnt_ff <= !press ? 28'h0000000 : long_held ? hold_cnt_ff
                     : hold_cnt_ff + 28'h0000001;
      rep_cnt_ff <= (!long_held || rep_due) ? 28'h0000000 : rep_cnt_ff + 28'h0000001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_NORMAL;
      sel_q_ff <= SEL_STORE;
      work_ff <= 16'sh0000;
      range_err_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      sel_q_ff <= in_test ? pnl.cal_sel : SEL_STORE;
      work_ff <= nxt_work;
      range_err_ff <= nxt_err;
    end
  end

  // Run LED
  logic [27:0] blink_cnt_ff;
  logic blink_ff;
  wire [27:0] blink_end = range_err_ff ? 28'(FAST_CYC - 1) : 28'(SLOW_CYC - 1);
  wire blink_wrap = blink_cnt_ff >= blink_end;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_ff <= 28'h0000000;
      blink_ff <= 1'b0;
    end else if (!adj_active) begin
      blink_cnt_ff <= 28'h0000000;
      blink_ff <= 1'b1;
    end else begin
      blink_cnt_ff <= blink_wrap ? 28'h0000000 : blink_cnt_ff + 28'h0000001;
      if (blink_wrap) blink_ff <= !blink_ff;
    end
  end
  logic led_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) led_ff <= 1'b0;
    else led_ff <= in_test ? (adj_active && blink_ff) : 1'b1;
  end
  assign run_led = led_ff;

  // Registers
  logic [31:0] ctrl_ff;
  logic [12:0] data_ff [NCH];
  logic [NEV-1:0] int_stat_ff, int_mask_ff;
  logic [31:0] rd_data_ff;
  wire conv_out_en = ctrl_ff[0];
  wire [7:0] chan_en = ctrl_ff[15:8];
  wire hit_data = bus.addr >= REG_DATA0 && bus.addr <= REG_DATA7 && bus.addr[1:0] == 2'h0;
  wire [2:0] data_idx = 3'((bus.addr - REG_DATA0) >> 2);
  wire [NEV-1:0] events;
  assign events[EV_TEST_ENTER] = test_enter;
  assign events[EV_TEST_EXIT] = test_exit;
  assign events[EV_STORED] = store_ok;
  assign events[EV_REJECTED] = store_try && range_err_ff;
  assign events[EV_RANGE] = nxt_err && !range_err_ff;
  wire [NEV-1:0] w1c = (bus.wr && bus.addr == REG_INT_STAT) ? bus.wdata[NEV-1:0] : '0;
  wire [31:0] status_word = {16'h0000, pnl.ch_sel, 2'h0, pnl.cal_sel,
                             3'h0, range_err_ff, cpu_run, pnl.retain_short, 1'b0, in_test};
  wire [31:0] rd_mux = !bus.rd ? 32'h0000_0000
                     : bus.addr == REG_CTRL ? ctrl_ff
                     : bus.addr == REG_STATUS ? status_word
                     : bus.addr == REG_INT_STAT ? 32'(int_stat_ff)
                     : bus.addr == REG_INT_MASK ? 32'(int_mask_ff)
                     : hit_data ? 32'(data_ff[data_idx])
                     : 32'h0000_0000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
      int_stat_ff <= '0;
      int_mask_ff <= MASK_RESET;
      rd_data_ff <= 32'h0000_0000;
    end else begin
      if (bus.wr && bus.addr == REG_CTRL) ctrl_ff <= {16'h0000, bus.wdata[15:8], 7'h00, bus.wdata[0]};
      if (bus.wr && bus.addr == REG_INT_MASK) int_mask_ff <= bus.wdata[NEV-1:0];
      // Set wins over a clear in the same cycle
      int_stat_ff <= (int_stat_ff & ~w1c) | events;
      rd_data_ff <= rd_mux;
    end
  end
  assign rd_data = rd_data_ff;
  assign irq = |(int_stat_ff & int_mask_ff);

  // Channel outputs
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_out
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) data_ff[i] <= 13'h0000;
        else if (bus.wr && hit_data && data_idx == 3'(i)) data_ff[i] <= bus.wdata[12:0];
      end
      wire run_ch = !in_test && conv_out_en && chan_en[i];
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          chan[i] <= '0;
        end else if (in_test) begin
          chan[i].active <= 1'b0;
        end else begin
          chan[i].offset <= st_offs[i];
          chan[i].gain <= st_gain[i];
          chan[i].active <= run_ch;
          if (!run_ch) chan[i].code <= CODE_CLEAR;
          else if (cpu_run) chan[i].code <= data_ff[i];
          else if (!pnl.retain_short) chan[i].code <= CODE_CLEAR;
        end
      end
    end
  endgenerate

  property p_halt;
    @(posedge ref_clk) disable iff (rst) in_test |=> !chan[0].active && !chan[7].active;
  endproperty
  a_halt: assert property (p_halt) else $error("Channel active in test mode");

  property p_edit_test;
    @(posedge ref_clk) disable iff (rst)
      (!in_test || !ch_valid) |=> $stable(st_offs) && $stable(st_gain);
  endproperty
  a_edit_test: assert property (p_edit_test) else $error("Store outside test mode");

  property p_enter;
    @(posedge ref_clk) disable iff (rst) pnl.test_short |=> in_test;
  endproperty
  a_enter: assert property (p_enter) else $error("Test mode not entered");

  property p_normal;
    @(posedge ref_clk) disable iff (rst) !pnl.test_short |=> !in_test;
  endproperty
  a_normal: assert property (p_normal) else $error("Normal mode not resumed");

  property p_freeze;
    @(posedge ref_clk) disable iff (rst) in_test |=> $stable(chan[0].code);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Output code moved in test mode");

  property p_ignore_ch;
    @(posedge ref_clk) disable iff (rst) (!ch_valid && !load_work) |=> $stable(work_ff);
  endproperty
  a_ignore_ch: assert property (p_ignore_ch) else $error("Invalid channel edited");

  property p_reject;
    @(posedge ref_clk) disable iff (rst)
      (store_try && range_err_ff) |=> $stable(st_offs) && $stable(st_gain);
  endproperty
  a_reject: assert property (p_reject) else $error("Out-of-range value stored");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      (!in_test && !cpu_run && !pnl.retain_short) |=> chan[0].code == CODE_CLEAR;
  endproperty
  a_clear: assert property (p_clear) else $error("Output not cleared on stop");

  wire run_ch_0 = conv_out_en && chan_en[0];
  property p_hold;
    @(posedge ref_clk) disable iff (rst)
      (!in_test && !cpu_run && pnl.retain_short && run_ch_0) |=> $stable(chan[0].code);
  endproperty
  a_hold: assert property (p_hold) else $error("Output not held on stop");

  property p_store;
    @(posedge ref_clk) disable iff (rst)
      store_ok |=> (($past(sel_q_ff) == SEL_GAIN) ? st_gain[$past(ch_idx)]
                    : st_offs[$past(ch_idx)]) == $past(work_ff);
  endproperty
  a_store: assert property (p_store) else $error("Value not committed");

  property p_led;
    @(posedge ref_clk) disable iff (rst) !in_test |=> run_led;
  endproperty
  a_led: assert property (p_led) else $error("Run LED off in normal mode");

  property p_led_store;
    @(posedge ref_clk) disable iff (rst) (in_test && !adj_active) |=> !run_led;
  endproperty
  a_led_store: assert property (p_led_store) else $error("Run LED lit at store position");

  property p_fast;
    @(posedge ref_clk) disable iff (rst)
      (adj_active && range_err_ff && $past(range_err_ff)) |-> blink_cnt_ff <= 28'(FAST_CYC - 1);
  endproperty
  a_fast: assert property (p_fast) else $error("Range flicker too slow");

  property p_irq;
    @(posedge ref_clk) disable iff (rst)
      (events[EV_STORED] && int_mask_ff[EV_STORED]) ##1 int_mask_ff[EV_STORED] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing after store");

  property p_step;
    @(posedge ref_clk) disable iff (rst)
      (step && !load_work && pnl.up) |=> work_ff == $past(work_ff) + 16'sh0001;
  endproperty
  a_step: assert property (p_step) else $error("Up step not applied");
endmodule

/* File: src/dacc_pkg.sv */
package dacc_pkg;
  localparam int NCH = 8;
  localparam int CLK_HZ = 100_000_000;
  // Times in milliseconds, cycle counts derived from the clock rate
  localparam int LONG_PRESS_MS = 1500;
  localparam int REPEAT_MS = 20;
  localparam int FAST_BLINK_MS = 100;
  localparam int SLOW_BLINK_MS = 500;
  localparam int DEBOUNCE_MS = 10;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
  localparam int REPEAT_CYC = REPEAT_MS * (CLK_HZ / 1000);
  localparam int FAST_BLINK_CYC = FAST_BLINK_MS * (CLK_HZ / 1000);
  localparam int SLOW_BLINK_CYC = SLOW_BLINK_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_DATA0 = 8'h10;
  localparam logic [7:0] REG_DATA7 = 8'h2C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [4:0] MASK_RESET = 5'h00;
  // Interrupt event bit positions
  localparam int EV_TEST_ENTER = 0;
  localparam int EV_TEST_EXIT = 1;
  localparam int EV_STORED = 2;
  localparam int EV_REJECTED = 3;
  localparam int EV_RANGE = 4;
  localparam int NEV = 5;
  // Calibration select switch codes
  localparam logic [1:0] SEL_STORE = 2'h0;
  localparam logic [1:0] SEL_OFFSET = 2'h1;
  localparam logic [1:0] SEL_GAIN = 2'h2;
  // Calibration in mV or uA, one step per count
  localparam logic signed [15:0] V_OFFS_DEF = 16'sh0000;
  localparam logic signed [15:0] V_GAIN_DEF = 16'sh2710;
  localparam logic signed [15:0] I_OFFS_DEF = 16'sh0FA0;
  localparam logic signed [15:0] I_GAIN_DEF = 16'sh4E20;
  localparam logic signed [15:0] V_MIN = -16'sh2710;
  localparam logic signed [15:0] V_MAX = 16'sh2710;
  localparam logic signed [15:0] I_MIN = 16'sh0000;
  localparam logic signed [15:0] I_MAX = 16'sh4E20;
  localparam logic [12:0] CODE_CLEAR = 13'h0000;

  typedef enum logic {MODE_NORMAL, MODE_TEST} dacc_mode_type;

  typedef struct packed {
    logic active;
    logic [12:0] code;
    logic signed [15:0] offset;
    logic signed [15:0] gain;
  } dacc_chan_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dacc_bus_type;

  typedef struct packed {
    logic test_short;
    logic retain_short;
    logic up;
    logic down;
    logic [1:0] cal_sel;
    logic [3:0] ch_sel;
  } dacc_panel_type;
endpackage

/* File: src/dacc_debounce.sv */
`timescale 1ns/1ps
module dacc_debounce import dacc_pkg::*; #(
  parameter int W = 10,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Raw and clean levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff, s2_ff, out_ff;
      logic [23:0] cnt_ff;
      wire differs = s2_ff != out_ff;
      wire done = cnt_ff == 24'(DEB_CYC - 1);
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          out_ff <= 1'b0;
          cnt_ff <= 24'h000000;
        end else begin
          s1_ff <= raw[i];
          s2_ff <= s1_ff;
          // New level must stay put for the full window
          cnt_ff <= (differs && !done) ? cnt_ff + 24'h000001 : 24'h000000;
          if (differs && done) out_ff <= s2_ff;
        end
      end
      assign clean[i] = out_ff;
    end
  endgenerate
endmodule

/* File: src/dacc_cal_store.sv */
`timescale 1ns/1ps
module dacc_cal_store import dacc_pkg::*; #(
  parameter logic CURRENT_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic wr_gain,
  input wire logic [2:0] wr_ch,
  input wire logic signed [15:0] wr_val,
  // Stored values
  output logic signed [NCH-1:0][15:0] offs,
  output logic signed [NCH-1:0][15:0] gain
);
  // Stands in for the nonvolatile cells; power-up restores defaults
  logic signed [15:0] offs_mem_ff [NCH];
  logic signed [15:0] gain_mem_ff [NCH];
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          offs_mem_ff[i] <= CURRENT_VARIANT ? I_OFFS_DEF : V_OFFS_DEF;
          gain_mem_ff[i] <= CURRENT_VARIANT ? I_GAIN_DEF : V_GAIN_DEF;
        end else if (wr_en && wr_ch == 3'(i)) begin
          if (wr_gain) gain_mem_ff[i] <= wr_val;
          else offs_mem_ff[i] <= wr_val;
        end
      end
      assign offs[i] = offs_mem_ff[i];
      assign gain[i] = gain_mem_ff[i];
    end
  endgenerate
endmodule

/* File: test/dacc_operator.sv */
`timescale 1ns/1ps
module dacc_operator import dacc_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Panel and host state
  output dacc_panel_type panel,
  output logic cpu_run
);
  initial begin
    panel = '0;
    cpu_run = 1'b0;
  end

  // Every level is held well past sync plus debounce
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  task automatic jumpers(input logic test, input logic retain);
    @(posedge ref_clk);
    panel.test_short <= test;
    panel.retain_short <= retain;
    settle();
  endtask

  task automatic host(input logic run);
    @(posedge ref_clk);
    cpu_run <= run;
    settle();
  endtask

  // Back to store first, else the pending value lands on the new channel
  task automatic select(input logic [1:0] sel, input logic [3:0] ch);
    if (ch !== panel.ch_sel && panel.cal_sel !== SEL_STORE) begin
      @(posedge ref_clk);
      panel.cal_sel <= SEL_STORE;
      settle();
    end
    @(posedge ref_clk);
    panel.cal_sel <= sel;
    panel.ch_sel <= ch;
    settle();
  endtask

  task automatic press(input logic up, input int cyc);
    @(posedge ref_clk);
    panel.up <= up;
    panel.down <= !up;
    repeat (cyc) @(posedge ref_clk);
    panel.up <= 1'b0;
    panel.down <= 1'b0;
    settle();
  endtask

  // One cycle only, too short for the debouncer
  task automatic glitch_test();
    @(posedge ref_clk);
    panel.test_short <= 1'b1;
    @(posedge ref_clk);
    panel.test_short <= 1'b0;
    settle();
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top import dacc_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  dacc_bus_type bus = '0;
  logic [31:0] rd_data;
  dacc_panel_type panel;
  logic cpu_run;
  dacc_chan_type [NCH-1:0] chan;
  logic run_led;
  logic irq;
  int mismatches = 0;
  int comparisons = 0;
  // Shortened timings so every scenario fits a short run
  localparam int SIM_LONG = 40;
  localparam int SIM_REP = 4;
  localparam int SIM_FAST = 4;
  localparam int SIM_SLOW = 12;
  localparam int SIM_DEB = 3;

  always #5 ref_clk = ~ref_clk;

  dacc_operator op (.ref_clk(ref_clk), .panel(panel), .cpu_run(cpu_run));

  dacc_ctrl #(.LONG_CYC(SIM_LONG), .REP_CYC(SIM_REP), .FAST_CYC(SIM_FAST),
              .SLOW_CYC(SIM_SLOW), .DEB_CYC(SIM_DEB)) uut (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .panel(panel),
    .cpu_run(cpu_run), .chan(chan), .run_led(run_led), .irq(irq));

  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    check(rd_data & m, e);
  endtask

  // Cycles until the run LED next changes
  task automatic led_period(output int n);
    logic l0;
    #1;
    l0 = run_led;
    n = 0;
    while (run_led === l0 && n < 40) begin
      tick(1);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      $display("mismatch at %0t: run led stuck", $time);
      final_report();
    end
  endtask

  task automatic sc_reset();
    reg_chk(REG_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    reg_chk(REG_INT_MASK, 32'hFFFF_FFFF, 32'h0);
    reg_chk(8'h30, 32'hFFFF_FFFF, 32'h0);
    reg_chk(REG_DATA0, 32'hFFFF_FFFF, 32'h0);
    tick(1);
    check(rd_data, 32'h0);
    check({31'h0, run_led}, 32'h1);
    check({16'h0, chan[0].gain}, {16'h0, V_GAIN_DEF});
    check({16'h0, chan[7].offset}, {16'h0, V_OFFS_DEF});
    reg_wr(REG_INT_MASK, 32'h0000_001F);
    reg_chk(REG_INT_MASK, 32'hFFFF_FFFF, 32'h0000_001F);
  endtask

  task automatic sc_output();
    reg_wr(REG_CTRL, 32'h0000_0101);
    reg_wr(REG_DATA0, 32'h0000_0ABC);
    reg_wr(REG_DATA0 + 8'h04, 32'h0000_0123);
    op.host(1'b1);
    check({18'h0, chan[0].active, chan[0].code}, 32'h0000_2ABC);
    check({18'h0, chan[1].active, chan[1].code}, 32'h0);
    reg_wr(REG_CTRL, 32'h0000_0100);
    tick(2);
    check({31'h0, chan[0].active}, 32'h0);
    reg_wr(REG_CTRL, 32'h0000_0101);
    op.host(1'b0);
    check({19'h0, chan[0].code}, 32'h0);
    op.jumpers(1'b0, 1'b1);
    op.host(1'b1);
    op.host(1'b0);
    check({19'h0, chan[0].code}, 32'h0000_0ABC);
    op.host(1'b1);
    op.select(SEL_OFFSET, 4'h1);
    op.press(1'b1, 8);
    op.select(SEL_STORE, 4'h1);
    check({16'h0, chan[0].offset}, {16'h0, V_OFFS_DEF});
  endtask

  task automatic sc_test();
    reg_wr(REG_INT_STAT, 32'h0000_001F);
    op.glitch_test();
    reg_chk(REG_STATUS, 32'h1, 32'h0);
    op.jumpers(1'b1, 1'b1);
    reg_chk(REG_STATUS, 32'h1, 32'h1);
    check({31'h0, chan[0].active}, 32'h0);
    check({31'h0, run_led}, 32'h0);
    reg_chk(REG_INT_STAT, 32'h1, 32'h1);
    check({31'h0, irq}, 32'h1);
    reg_wr(REG_INT_STAT, 32'h0000_001F);
    tick(1);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic sc_cal();
    int n;
    op.select(SEL_OFFSET, 4'h1);
    led_period(n);
    led_period(n);
    check({31'h0, n >= 8}, 32'h1);
    op.press(1'b1, 8);
    op.press(1'b1, 8);
    op.press(1'b1, 60);
    op.select(SEL_STORE, 4'h1);
    reg_chk(REG_INT_STAT, 32'h4, 32'h4);
    // Gain already at full scale, one step up leaves the range
    op.select(SEL_GAIN, 4'h1);
    op.press(1'b1, 8);
    reg_chk(REG_STATUS, 32'h10, 32'h10);
    led_period(n);
    led_period(n);
    check({31'h0, n <= 5}, 32'h1);
    op.select(SEL_STORE, 4'h1);
    reg_chk(REG_INT_STAT, 32'h8, 32'h8);
    reg_wr(REG_INT_STAT, 32'h0000_001F);
    op.select(SEL_OFFSET, 4'h0);
    op.press(1'b1, 8);
    op.select(SEL_STORE, 4'h0);
    reg_chk(REG_INT_STAT, 32'h4, 32'h0);
    op.select(SEL_GAIN, 4'h2);
    op.press(1'b0, 8);
    op.jumpers(1'b0, 1'b1);
    reg_chk(REG_INT_STAT, 32'h2, 32'h2);
    check({31'h0, chan[0].offset >= 16'sd6 && chan[0].offset <= 16'sd10}, 32'h1);
    check({16'h0, chan[0].gain}, {16'h0, V_GAIN_DEF});
    check({16'h0, chan[1].gain}, {16'h0, V_GAIN_DEF});
    check({31'h0, chan[0].active}, 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    tick(2);
    sc_reset();
    sc_output();
    sc_test();
    sc_cal();
    final_report();
  end
endmodule
